// File: rtl/host_port_pkg.sv
// shared constants and types of the host port block
package host_port_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CLKOUT_REG_ADDR = 8'h1f;
    localparam logic [7:0] CLKOUT_REG_RESET = 8'h00;
    localparam int DIV_FIELD_LSB = 0;
    localparam int DIV_FIELD_W = 4;
    localparam logic [3:0] DIV_MIN = 4'h2;
    localparam logic [3:0] DIV_MAX = 4'hf;

    // ****************************************
    // parallel bus modes (mode pins)
    // ****************************************
    localparam logic [1:0] MODE_MUX8 = 2'h0;
    localparam logic [1:0] MODE_MUX16 = 2'h1;
    localparam logic [1:0] MODE_MUX8_STROBE = 2'h2;
    localparam logic [1:0] MODE_NONMUX8 = 2'h3;

    // ****************************************
    // serial framing
    // ****************************************
    localparam int SER_FRAME_BITS = 16;
    localparam logic [4:0] SER_FRAME_LEN = 5'h10;
    localparam logic [4:0] SER_DATA_START = 5'h08;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cs_level_high;
        logic sample_falling;
        logic idle_high;
    } serial_cfg_t;

    typedef struct packed {
        logic [1:0] mode;
        logic serial_mode;
        serial_cfg_t cfg;
        logic latch_strobe;
        logic chip_select;
        logic rd_n;
        logic wr_n;
        logic sclk;
        logic mosi;
        logic [15:0] wide_bus;
        logic [7:0] addr_bus;
        logic [7:0] data_bus;
    } pin_in_t;

    localparam int PIN_IN_W = $bits(pin_in_t);

endpackage

// File: rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// File: rtl/host_port_top.sv
// host pin interface: address latching, chip select, serial sampling, clock output
//
// Summary of operation
// - modes 0/1 latch address while latch enable high
// - mode 2 latches address on address strobe
// - clock output is crystal or crystal/n, n 2..15
// - serial samples rising edge or falling edge
// - parallel modes: access only while select low
// - serial select polarity chosen by polarity pin
// - mode 3 eight dedicated bidirectional data lines
// - mode 3 eight dedicated address input lines
// - mode 1 sixteen lines: address then data
// - serial clock idle level chosen by pin
`timescale 1ns/1ps
`default_nettype none
module host_port_top
    import host_port_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic serial_mode_i,
    input wire logic select_polarity_pin_i,
    input wire logic sample_edge_select_i,
    input wire logic idle_level_select_i,
    input wire logic addr_strobe_i,
    input wire logic chip_select_in_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic serial_bit_clock_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    input wire logic [15:0] muxed_wide_bus_i,
    output logic [15:0] muxed_wide_bus_o,
    output logic muxed_wide_bus_oe_o,
    input wire logic [7:0] mode3_addr_bus_i,
    input wire logic [7:0] mode3_data_bus_i,
    output logic [7:0] mode3_data_bus_o,
    output logic mode3_data_bus_oe_o,
    output logic [7:0] clock_output_divider_o,
    output logic divided_clock_output_o
);

    // ****************************************
    // pin synchronisation
    // ****************************************
    pin_in_t pin_raw;
    pin_in_t pin;

    assign pin_raw = '{mode: mode_i, serial_mode: serial_mode_i,
                       cfg: '{cs_level_high: select_polarity_pin_i,
                              sample_falling: sample_edge_select_i,
                              idle_high: idle_level_select_i},
                       latch_strobe: addr_strobe_i, chip_select: chip_select_in_i,
                       rd_n: rd_n_i, wr_n: wr_n_i, sclk: serial_bit_clock_i,
                       mosi: serial_data_in_i, wide_bus: muxed_wide_bus_i,
                       addr_bus: mode3_addr_bus_i, data_bus: mode3_data_bus_i};

    pin_sync #(.W(PIN_IN_W)) pin_sync_inst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i(pin_raw),
        .sync_o(pin)
    );

    // ****************************************
    // chip select and strobes
    // ****************************************
    logic cs_active;
    logic wr_prev;
    logic sclk_prev;
    logic wr_fall;
    logic mode_nonmux;
    logic latch_open;

    // parallel modes: select active low; serial: polarity from pin
    assign cs_active = pin.serial_mode ? (pin.chip_select == pin.cfg.cs_level_high)
                                       : ~pin.chip_select;
    assign mode_nonmux = (pin.mode == MODE_NONMUX8);
    // modes 0..2 share the latch pin; mode 3 has it tied high and never latches from it
    assign latch_open = ~pin.serial_mode & ~mode_nonmux & pin.latch_strobe;
    assign wr_fall = wr_prev & ~pin.wr_n;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // same level as the flushed synchroniser, so no false write edge follows reset
            wr_prev <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            wr_prev <= pin.wr_n;
            sclk_prev <= pin.sclk;
        end
    end

    // ****************************************
    // address latch
    // ****************************************
    logic [15:0] addr_latched;
    logic [15:0] next_addr_latched;
    logic [15:0] access_addr;
    logic [7:0] access_wdata;
    logic par_hit;
    logic par_write;
    logic par_read;

    // transparent while the strobe is high, holds after it falls
    assign next_addr_latched = (pin.mode == MODE_MUX16) ? pin.wide_bus
                                                        : {8'h00, pin.wide_bus[7:0]};
    assign access_addr = mode_nonmux ? {8'h00, pin.addr_bus} : addr_latched;
    assign access_wdata = mode_nonmux ? pin.data_bus : pin.wide_bus[7:0];
    assign par_hit = (access_addr == {8'h00, CLKOUT_REG_ADDR});
    assign par_write = ~pin.serial_mode & cs_active & wr_fall & par_hit;
    assign par_read = ~pin.serial_mode & cs_active & ~pin.rd_n & pin.wr_n;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_latched <= '0;
        end else if (latch_open) begin
            addr_latched <= next_addr_latched;
        end
    end

    // ****************************************
    // serial interface
    // ****************************************
    logic sclk_rise;
    logic sclk_fall;
    logic sample_edge;
    logic frame_ok;
    logic [15:0] ser_shift;
    logic [4:0] ser_count;
    logic ser_write;
    logic cs_prev;
    logic cs_start;
    logic [7:0] ser_addr_seen;

    // the address byte sits just above the bits shifted in after it
    assign ser_addr_seen = ser_shift[4'(ser_count - 5'h01) -: 8];

    assign sclk_rise = ~sclk_prev & pin.sclk;
    assign sclk_fall = sclk_prev & ~pin.sclk;
    assign sample_edge = pin.cfg.sample_falling ? sclk_fall : sclk_rise;
    assign cs_start = pin.serial_mode & cs_active & ~cs_prev;
    assign ser_write = pin.serial_mode & cs_active & frame_ok & sample_edge
                       & (ser_count == SER_FRAME_LEN - 5'h01)
                       & (ser_shift[14:7] == CLKOUT_REG_ADDR);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cs_prev <= 1'b0;
            frame_ok <= 1'b0;
            ser_shift <= '0;
            ser_count <= '0;
        end else begin
            cs_prev <= pin.serial_mode & cs_active;
            if (cs_start) begin
                // a frame counts only if the clock sits at its idle level at select
                frame_ok <= (pin.sclk == pin.cfg.idle_high);
                ser_count <= '0;
            end else if (~cs_active | ~pin.serial_mode) begin
                frame_ok <= 1'b0;
                ser_count <= '0;
            end else if (frame_ok & sample_edge & (ser_count != SER_FRAME_LEN)) begin
                ser_shift <= {ser_shift[14:0], pin.mosi};
                ser_count <= ser_count + 5'h01;
            end
        end
    end

    // ****************************************
    // clock output register
    // ****************************************
    logic [7:0] clkout_reg;
    logic [3:0] div_n;
    logic div_bypass;

    assign div_n = clkout_reg[DIV_FIELD_LSB +: DIV_FIELD_W];
    assign div_bypass = (div_n < DIV_MIN);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clkout_reg <= CLKOUT_REG_RESET;
        end else if (par_write) begin
            clkout_reg <= access_wdata;
        end else if (ser_write) begin
            clkout_reg <= {ser_shift[6:0], pin.mosi};
        end
    end

    assign clock_output_divider_o = clkout_reg;

    // ****************************************
    // clock divider
    // ****************************************
    logic [3:0] div_count;
    logic div_out;
    logic [3:0] half_n;

    assign half_n = div_n >> 1;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_count <= '0;
            div_out <= 1'b0;
        end else if (div_bypass | (div_count >= div_n - 4'h1)) begin
            div_count <= '0;
            div_out <= 1'b1;
        end else begin
            div_count <= div_count + 4'h1;
            div_out <= (div_count + 4'h1 < half_n);
        end
    end

    // n below 2 passes the crystal clock straight through
    assign divided_clock_output_o = div_bypass ? clk_sys_i : div_out;

    // ****************************************
    // read data drivers
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            muxed_wide_bus_o <= '0;
            muxed_wide_bus_oe_o <= 1'b0;
            mode3_data_bus_o <= '0;
            mode3_data_bus_oe_o <= 1'b0;
            serial_data_out_o <= 1'b0;
        end else begin
            muxed_wide_bus_o <= {8'h00, par_hit ? clkout_reg : 8'h00};
            muxed_wide_bus_oe_o <= par_read & ~mode_nonmux;
            mode3_data_bus_o <= par_hit ? clkout_reg : 8'h00;
            mode3_data_bus_oe_o <= par_read & mode_nonmux;
            serial_data_out_o <= (ser_count >= SER_DATA_START) & (ser_addr_seen == CLKOUT_REG_ADDR)
                                 ? clkout_reg[3'(SER_FRAME_LEN - 5'h01 - ser_count)] : 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    mux_latch_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (latch_open && pin.mode == MODE_MUX8) |=> addr_latched == {8'h00, $past(pin.wide_bus[7:0])})
        else $error("address not latched in mode 0");
    wide_latch_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (latch_open && pin.mode == MODE_MUX16) |=> addr_latched == $past(pin.wide_bus))
        else $error("wide address not latched");
    latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !latch_open |=> $stable(addr_latched))
        else $error("address changed with strobe low");
    no_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!pin.serial_mode && pin.chip_select) |=> !muxed_wide_bus_oe_o && !mode3_data_bus_oe_o)
        else $error("bus driven while deselected");
    cs_polarity_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pin.serial_mode |-> cs_active == (pin.chip_select ~^ pin.cfg.cs_level_high))
        else $error("serial select polarity wrong");
    sample_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (frame_ok && cs_active && pin.serial_mode && ser_count < SER_FRAME_LEN - 5'h01
         && (pin.cfg.sample_falling ? sclk_fall : sclk_rise))
        |=> ser_shift[0] == $past(pin.mosi) && ser_count == $past(ser_count) + 5'h01)
        else $error("serial bit not sampled on chosen edge");
    mode3_data_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (par_write && mode_nonmux) |=> clkout_reg == $past(pin.data_bus))
        else $error("mode 3 write data wrong");
    div_period_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!div_bypass && div_count == 4'h0 && $past(div_count) != 4'h0)
        |=> div_count == 4'h1 && div_out == (4'h1 < ($past(div_n) >> 1)))
        else $error("divider does not count");
endmodule
`default_nettype wire

// File: sim/host_cpu_model.sv
// host cpu model driving the device pins in parallel and serial modes
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
    import host_port_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [15:0] muxed_wide_bus_o,
    input wire logic [7:0] mode3_data_bus_o,
    input wire logic muxed_wide_bus_oe_o,
    input wire logic mode3_data_bus_oe_o,
    input wire logic serial_data_out_o,
    output var pin_in_t pins_o
);
    initial begin
        pins_o = '0;
        pins_o.chip_select = 1'b1;
        pins_o.rd_n = 1'b1;
        pins_o.wr_n = 1'b1;
    end

    // ****************************************
    // parallel access: address phase, then strobe phase
    // ****************************************
    task automatic par_xfer(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d,
                            input logic sel, input logic rd, output logic [7:0] q, output logic drv);
        @(posedge clk_sys_i);
        pins_o.mode <= m;
        pins_o.serial_mode <= 1'b0;
        pins_o.latch_strobe <= 1'b1;
        pins_o.wide_bus <= a;
        pins_o.addr_bus <= a[7:0];
        repeat (4) @(posedge clk_sys_i);
        pins_o.latch_strobe <= (m == MODE_NONMUX8);
        @(posedge clk_sys_i);
        pins_o.chip_select <= ~sel;
        pins_o.rd_n <= ~rd;
        pins_o.wr_n <= rd;
        pins_o.wide_bus <= rd ? ~a : {~d, d};
        pins_o.data_bus <= rd ? ~d : d;
        repeat (5) @(posedge clk_sys_i);
        drv = (m == MODE_NONMUX8) ? (mode3_data_bus_oe_o & ~muxed_wide_bus_oe_o)
                                  : (muxed_wide_bus_oe_o & ~mode3_data_bus_oe_o);
        q = (m == MODE_NONMUX8) ? mode3_data_bus_o : muxed_wide_bus_o[7:0];
        pins_o.chip_select <= 1'b1;
        pins_o.rd_n <= 1'b1;
        pins_o.wr_n <= 1'b1;
        pins_o.wide_bus <= ~pins_o.wide_bus;
        pins_o.data_bus <= ~pins_o.data_bus;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // ****************************************
    // serial frame: eight address bits then eight data bits, msb first
    // ****************************************
    task automatic ser_write(input serial_cfg_t c, input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q);
        logic [15:0] frame;
        frame = {a, d};
        q = 8'h00;
        @(posedge clk_sys_i);
        pins_o.serial_mode <= 1'b1;
        pins_o.cfg <= c;
        pins_o.chip_select <= ~c.cs_level_high;
        pins_o.sclk <= c.idle_high;
        repeat (4) @(posedge clk_sys_i);
        pins_o.chip_select <= c.cs_level_high;
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(posedge clk_sys_i);
            pins_o.sclk <= c.sample_falling;
            pins_o.mosi <= frame[i];
            repeat (4) @(posedge clk_sys_i);
            // read-back bit settled well before the next sampling edge
            if (i < 8) begin
                q[i] = serial_data_out_o;
            end
            pins_o.sclk <= ~c.sample_falling;
        end
        repeat (4) @(posedge clk_sys_i);
        pins_o.sclk <= c.idle_high;
        pins_o.mosi <= ~pins_o.mosi;
        repeat (4) @(posedge clk_sys_i);
        pins_o.chip_select <= ~c.cs_level_high;
        repeat (4) @(posedge clk_sys_i);
        pins_o.serial_mode <= 1'b0;
        @(posedge clk_sys_i);
        pins_o.chip_select <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_host_bus_pin_mode_decode.sv
// self-checking testbench of the host port block
`timescale 1ns/1ps
`default_nettype none
`define chk_eq(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_host_bus_pin_mode_decode;
    import host_port_pkg::*;
    logic clk_sys_i;
    logic rst_i;
    pin_in_t pins;
    logic [15:0] muxed_wide_bus_o;
    logic [7:0] mode3_data_bus_o;
    logic muxed_wide_bus_oe_o;
    logic mode3_data_bus_oe_o;
    logic serial_data_out_o;
    logic [7:0] clock_output_divider_o;
    logic divided_clock_output_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    host_port_top host_port_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_i(pins.mode),
        .serial_mode_i(pins.serial_mode), .select_polarity_pin_i(pins.cfg.cs_level_high),
        .sample_edge_select_i(pins.cfg.sample_falling), .idle_level_select_i(pins.cfg.idle_high),
        .addr_strobe_i(pins.latch_strobe), .chip_select_in_i(pins.chip_select), .rd_n_i(pins.rd_n),
        .wr_n_i(pins.wr_n), .serial_bit_clock_i(pins.sclk), .serial_data_in_i(pins.mosi),
        .serial_data_out_o(serial_data_out_o), .muxed_wide_bus_i(pins.wide_bus),
        .muxed_wide_bus_o(muxed_wide_bus_o), .muxed_wide_bus_oe_o(muxed_wide_bus_oe_o),
        .mode3_addr_bus_i(pins.addr_bus), .mode3_data_bus_i(pins.data_bus),
        .mode3_data_bus_o(mode3_data_bus_o), .mode3_data_bus_oe_o(mode3_data_bus_oe_o),
        .clock_output_divider_o(clock_output_divider_o), .divided_clock_output_o(divided_clock_output_o));

    host_cpu_model host_cpu_model_inst (.clk_sys_i(clk_sys_i), .muxed_wide_bus_o(muxed_wide_bus_o),
        .mode3_data_bus_o(mode3_data_bus_o), .muxed_wide_bus_oe_o(muxed_wide_bus_oe_o),
        .mode3_data_bus_oe_o(mode3_data_bus_oe_o), .serial_data_out_o(serial_data_out_o), .pins_o(pins));

    // ****************************************
    // expectations and helpers
    // ****************************************
    function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic sel,
                                           input logic [7:0] d, input logic [7:0] old);
        return (sel && a == CLKOUT_REG_ADDR) ? d : old;
    endfunction

    // cycles between two rising samples of the clock output
    task automatic measure(output logic [7:0] per);
        int k;
        k = 0;
        while (divided_clock_output_o !== 1'b0 && k < 64) begin @(posedge clk_sys_i); k++; end
        while (divided_clock_output_o !== 1'b1 && k < 64) begin @(posedge clk_sys_i); k++; end
        per = 8'h00;
        do begin @(posedge clk_sys_i); per++; end while (divided_clock_output_o === 1'b1 && per < 64);
        while (divided_clock_output_o !== 1'b1 && per < 64) begin @(posedge clk_sys_i); per++; end
    endtask

    task automatic complete_run();
        $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] q;
        logic [7:0] d;
        logic [7:0] per;
        logic [7:0] r;
        logic [15:0] a;
        logic sel;
        logic drv;
        rst_i = 1'b1;
        void'($urandom(73811));
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        `chk_eq(clock_output_divider_o, CLKOUT_REG_RESET)
        // undivided after reset: the output follows the crystal clock in both phases
        #1;
        `chk_eq(divided_clock_output_o, clk_sys_i)
        #5;
        `chk_eq(divided_clock_output_o, clk_sys_i)
        r = CLKOUT_REG_RESET;
        // every divisor, spread over all four bus modes, with read-back in the next mode
        for (int n = 2; n <= 15; n++) begin
            d = {4'($urandom()), 4'(n)};
            host_cpu_model_inst.par_xfer(2'(n), 16'h001f, d, 1'b1, 1'b0, q, drv);
            r = exp_reg(8'h1f, 1'b1, d, r);
            `chk_eq(clock_output_divider_o, r)
            measure(per);
            `chk_eq(per, 8'(n))
            host_cpu_model_inst.par_xfer(2'(n + 1), 16'h001f, 8'h00, 1'b1, 1'b1, q, drv);
            `chk_eq(q, r)
            `chk_eq(drv, 1'b1)
        end
        // refused writes: deselected, unmapped, both
        for (int j = 0; j < 3; j++) begin
            a = (j == 0) ? 16'h001f : 16'h001e;
            sel = (j == 1);
            d = 8'($urandom());
            host_cpu_model_inst.par_xfer(2'(j), a, d, sel, 1'b0, q, drv);
            r = exp_reg(a[7:0], sel, d, r);
            `chk_eq(clock_output_divider_o, r)
            host_cpu_model_inst.par_xfer(2'(j + 1), a, 8'h00, 1'b1, 1'b1, q, drv);
            `chk_eq(q, exp_reg(a[7:0], 1'b1, r, 8'h00))
            // deselected read of the mapped register: the mode's own lane must not be the only one driven
            host_cpu_model_inst.par_xfer(2'(j + 2), 16'h001f, 8'h00, 1'b0, 1'b1, q, drv);
            `chk_eq(drv, 1'b0)
        end
        // serial frames over every polarity, edge and idle combination
        for (int i = 0; i < 9; i++) begin
            d = 8'($urandom());
            a = (i == 8) ? 16'h001e : 16'h001f;
            host_cpu_model_inst.ser_write(serial_cfg_t'(3'(i)), a[7:0], d, q);
            `chk_eq(q, (a[7:0] == CLKOUT_REG_ADDR) ? r : 8'h00)
            r = exp_reg(a[7:0], 1'b1, d, r);
            `chk_eq(clock_output_divider_o, r)
        end
        complete_run();
    end
endmodule
`undef chk_eq
`default_nettype wire
